// ==== rmls_pkg.sv ====
// Package: constants and types for the receive mode, rate and lock status block
package rmls_pkg;
  // Rate select levels on the pin
  localparam logic RATE_HD      = 1'b0;
  localparam logic RATE_SD      = 1'b1;
  // Reset values
  localparam logic RST_LOCK     = 1'b0;
  localparam logic RST_FLAG     = 1'b0;
  localparam logic RST_MODE     = 1'b0;
  localparam logic RST_RATE     = 1'b1;
  localparam logic RST_MUTE     = 1'b1;
  localparam logic RST_DECODE   = 1'b0;
  localparam logic RST_PATH_A   = 1'b1;
  // Synchroniser idle: input A, carriers invalid, rate pin pulled up
  localparam logic [7:0] RST_SYNC = 8'h4D;
  // Output enable levels (low = driving)
  localparam logic OE_DRIVE     = 1'b0;
  localparam logic OE_RELEASE   = 1'b1;

  typedef enum logic [1:0] {
    RMLS_SMPTE  = 2'b00,
    RMLS_ASI    = 2'b01,
    RMLS_THRU   = 2'b10
  } rmls_mode_t;
endpackage

// ==== rmls_top.sv ====
// Mode, rate, lock and chroma ancillary status logic of the deserializer
// Operation
// [RULE1] Master select high: device drives mode/rate pins; low: host drives them.
// [RULE2] Mode and rate pins are inputs in slave mode, outputs in master mode.
// [RULE3] Master: mode pin high only while locked to compliant ASI stream.
// [RULE4] Slave: ASI reception only with mode high, rate high, processing select low.
// [RULE5] Slave with mode pin low: no ASI word alignment or decoding.
// [RULE6] Lock indicator high while locked to compliant data of current mode.
// [RULE7] HD: chroma anc flag follows anc detection in chroma stream.
// [RULE8] SD 20-bit: chroma anc flag follows chroma-stream anc detection only.
// [RULE9] SD 10-bit: chroma anc flag follows anc detected anywhere in stream.
// [RULE10] Master: rate pin low for either HD serial rate.
// [RULE11] Master: rate pin high for SD serial rate.
// [RULE12] Slave rate low: accept and lock only HD-rate signals.
// [RULE13] Slave rate high: accept and lock only SD-rate signals.
// [RULE14] Host resets device after setting and after changing slave rate.
// [RULE15] Selected input valid while its active-low carrier detect is low.
// [RULE16] Carrier detect high: input invalid, lock low, parallel outputs muted.
// [RULE17] Input select high picks input A and detect A; low picks B.
// [RULE18] Output drive on mode and rate pins released whenever slave selected.
`timescale 1ns/1ps
module rmls_top
  import rmls_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // Mode selection pins
  input  wire logic master_sel_i,
  input  wire logic input_select_i,
  input  wire logic smpte_processing_select_i,
  input  wire logic bus_width_select_i,
  // Carrier detect, active low
  input  wire logic carrier_detect_a_n_i,
  input  wire logic carrier_detect_b_n_i,
  // Two-way transport mode pin
  input  wire logic asi_mode_pin_i,
  output logic      asi_mode_pin_o,
  output logic      asi_mode_pin_oe_n_o,
  // Two-way rate select pin
  input  wire logic rate_select_pin_i,
  output logic      rate_select_pin_o,
  output logic      rate_select_pin_oe_n_o,
  // Core status from the receive datapath (same clock)
  input  wire logic rx_rate_sd_i,
  input  wire logic rx_rate_valid_i,
  input  wire logic rx_smpte_lock_i,
  input  wire logic rx_asi_lock_i,
  input  wire logic anc_chroma_i,
  input  wire logic anc_any_i,
  // Status and control outputs
  output logic      locked_o,
  output logic      chroma_anc_flag_o,
  output logic      output_mute_o,
  output logic      path_select_a_o,
  output logic      asi_decode_en_o,
  output logic      rate_is_sd_o
);
  import rmls_pkg::*;

  // Pin synchronisers
  // Reset to idle levels so no false mode or carrier follows reset
  logic [7:0] s1_q, s2_q;
  logic [7:0] pins;
  assign pins = {master_sel_i, input_select_i, smpte_processing_select_i,
                 bus_width_select_i, carrier_detect_a_n_i, carrier_detect_b_n_i,
                 asi_mode_pin_i, rate_select_pin_i};
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= RST_SYNC;
      s2_q <= RST_SYNC;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  logic master, sel_a, proc_sel, width20, cd_a_n, cd_b_n, host_asi, host_sd;
  assign {master, sel_a, proc_sel, width20, cd_a_n, cd_b_n, host_asi, host_sd} = s2_q;

  logic locked_q, locked_d, flag_q, flag_d, mute_q, mute_d, sela_q, sela_d;
  logic asi_q, asi_d, rate_q, rate_d, oe_q, oe_d, dec_q, dec_d, sd_q, sd_d;
  logic carrier_ok, rate_ok, cur_sd, mode_asi;
  rmls_mode_t mode;

  always_comb begin
    carrier_ok = sel_a ? !cd_a_n : !cd_b_n; // [RULE17] [RULE15]
    cur_sd     = master ? rx_rate_sd_i : host_sd;
    // Slave restricts lock to the configured rate
    rate_ok    = master ? rx_rate_valid_i
                        : (rx_rate_valid_i && (rx_rate_sd_i == host_sd)); // [RULE12] [RULE13]
    // Slave mode is host chosen; master follows detected lock
    mode_asi   = master ? rx_asi_lock_i
                        : (host_asi && host_sd && !proc_sel); // [RULE4] [RULE5]
    if (mode_asi)
      mode = RMLS_ASI;
    else if (!master && !proc_sel)
      mode = RMLS_THRU;
    else
      mode = RMLS_SMPTE;
    case (mode)
      RMLS_ASI:   locked_d = carrier_ok && rate_ok && rx_asi_lock_i; // [RULE6]
      RMLS_SMPTE: locked_d = carrier_ok && rate_ok && rx_smpte_lock_i; // [RULE6]
      default:    locked_d = 1'b0;
    endcase
    if (!carrier_ok)
      locked_d = 1'b0; // [RULE16]
    mute_d = !carrier_ok; // [RULE16]
    dec_d  = mode_asi && carrier_ok; // [RULE5]
    if (!cur_sd || width20)
      flag_d = anc_chroma_i && carrier_ok; // [RULE7] [RULE8]
    else
      flag_d = anc_any_i && carrier_ok; // [RULE9]
    asi_d  = master && carrier_ok && rate_ok && rx_asi_lock_i; // [RULE3]
    rate_d = rx_rate_sd_i ? RATE_SD : RATE_HD; // [RULE10] [RULE11]
    oe_d   = master ? OE_DRIVE : OE_RELEASE; // [RULE1] [RULE2] [RULE18]
    sela_d = sel_a;
    sd_d   = cur_sd;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      locked_q <= RST_LOCK;
      flag_q   <= RST_FLAG;
      mute_q   <= RST_MUTE;
      asi_q    <= RST_MODE;
      rate_q   <= RST_RATE;
      oe_q     <= OE_RELEASE;
      dec_q    <= RST_DECODE;
      sela_q   <= RST_PATH_A;
      sd_q     <= RST_RATE;
    end else begin
      locked_q <= locked_d;
      flag_q   <= flag_d;
      mute_q   <= mute_d;
      asi_q    <= asi_d;
      rate_q   <= rate_d;
      oe_q     <= oe_d;
      dec_q    <= dec_d;
      sela_q   <= sela_d;
      sd_q     <= sd_d;
    end
  end

  assign locked_o               = locked_q;
  assign chroma_anc_flag_o      = flag_q;
  assign output_mute_o          = mute_q;
  assign asi_mode_pin_o         = asi_q;
  assign rate_select_pin_o      = rate_q;
  assign asi_mode_pin_oe_n_o    = oe_q;
  assign rate_select_pin_oe_n_o = oe_q;
  assign asi_decode_en_o        = dec_q;
  assign path_select_a_o        = sela_q;
  assign rate_is_sd_o           = sd_q;

  // Pin direction
  a_oe_release: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE18]
    !master |=> rate_select_pin_oe_n_o && asi_mode_pin_oe_n_o)
    else $error("pin drive not released in slave mode");
  a_oe_drive: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE2]
    master |=> !asi_mode_pin_oe_n_o)
    else $error("pin not driven in master mode");
  a_rate_drive: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE1]
    master |=> !rate_select_pin_oe_n_o)
    else $error("rate pin not driven in master mode");

  // Mode and rate pins
  a_asi_pin_lock: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE3]
    asi_mode_pin_o |-> $past(rx_asi_lock_i) && $past(master))
    else $error("mode pin high without asi lock");
  a_asi_pin_low: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE3]
    (master && !rx_asi_lock_i) |=> !asi_mode_pin_o)
    else $error("mode pin not low without asi lock");
  a_rate_pin_hd: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE10]
    !rx_rate_sd_i |=> !rate_select_pin_o)
    else $error("rate pin not low for hd");
  a_rate_pin_sd: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE11]
    rx_rate_sd_i |=> rate_select_pin_o)
    else $error("rate pin not high for sd");

  // Lock, carrier and decode
  a_lock_carrier: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE16]
    !carrier_ok |=> !locked_o && output_mute_o)
    else $error("lock or mute wrong with carrier lost");
  a_mute_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE15]
    carrier_ok |=> !output_mute_o)
    else $error("outputs muted with carrier present");
  a_path_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE17]
    1'b1 |=> path_select_a_o == $past(sel_a))
    else $error("path select does not follow input select");
  a_slave_rate: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE12]
    (!master && rx_rate_sd_i != host_sd) |=> !locked_o)
    else $error("lock at wrong slave rate");
  a_slave_noasi: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE5]
    (!master && !host_asi) |=> !asi_decode_en_o)
    else $error("asi decode with mode pin low");
  a_slave_asi_on: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE4]
    (!master && host_asi && host_sd && !proc_sel && carrier_ok) |=> asi_decode_en_o)
    else $error("asi decode off in slave asi setup");
  a_thru_nolock: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE6]
    (!master && !proc_sel && !(host_asi && host_sd)) |=> !locked_o)
    else $error("lock reported in data-through");
  a_lock_smpte: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE6]
    (master && carrier_ok && rx_rate_valid_i && !rx_asi_lock_i)
    |=> locked_o == $past(rx_smpte_lock_i))
    else $error("lock wrong in master smpte");
  a_slave_lock_asi: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE4]
    (!master && host_asi && host_sd && !proc_sel && carrier_ok && rate_ok)
    |=> locked_o == $past(rx_asi_lock_i))
    else $error("lock wrong in slave asi");

  // Ancillary flag
  a_anc_10bit: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE9]
    (cur_sd && !width20 && carrier_ok) |=> chroma_anc_flag_o == $past(anc_any_i))
    else $error("anc flag wrong in sd 10-bit");
  a_anc_20bit: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE8]
    (cur_sd && width20 && carrier_ok) |=> chroma_anc_flag_o == $past(anc_chroma_i))
    else $error("anc flag wrong in sd 20-bit");
  a_anc_chroma: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE7]
    (!cur_sd && carrier_ok) |=> chroma_anc_flag_o == $past(anc_chroma_i))
    else $error("anc flag wrong in hd");

  c_master_lock: cover property (@(posedge mclk_i) disable iff (!nrst_i) master && locked_o);
  c_slave_asi: cover property (@(posedge mclk_i) disable iff (!nrst_i) !master && asi_decode_en_o);
  c_carrier_loss: cover property (@(posedge mclk_i) disable iff (!nrst_i) $fell(carrier_ok));
  c_anc_flag: cover property (@(posedge mclk_i) disable iff (!nrst_i) chroma_anc_flag_o);
  c_slave_refuse: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    !master && rx_rate_valid_i && rx_rate_sd_i != host_sd);
endmodule

// ==== rmls_host_model.sv ====
// Host and equalizer side model resolving the two-way pins
`timescale 1ns/1ps
module rmls_host_model (
  // Host levels
  input  wire logic host_asi_i,
  input  wire logic host_rate_i,
  // Device drive
  input  wire logic dev_asi_i,
  input  wire logic dev_asi_oe_n_i,
  input  wire logic dev_rate_i,
  input  wire logic dev_rate_oe_n_i,
  // Wire levels
  output logic      asi_wire_o,
  output logic      rate_wire_o
);
  // Host drives only while the device has released
  assign asi_wire_o  = dev_asi_oe_n_i ? host_asi_i : dev_asi_i;
  assign rate_wire_o = dev_rate_oe_n_i ? host_rate_i : dev_rate_i;
endmodule

// ==== tb.sv ====
// Self-checking bench for the mode, rate and lock status block
`timescale 1ns/1ps
module tb;
  import rmls_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ms = 1'b0, isel = 1'b1, prc = 1'b0, bw = 1'b0, cda = 1'b1, cdb = 1'b1;
  logic ha = 1'b0, hr = 1'b1, sd = 1'b0, rv = 1'b0, sl = 1'b0, al = 1'b0;
  logic ac = 1'b0, aa = 1'b0, cok, rt, asim, ex, oe;
  wire logic aw, rw, ao, aoe, ro, roe, lk, fl, mu, pa, de, rs;
  int bad_count = 0;
  int checked = 0;
  int seed = 32'hCD8A0D4F;
  always #2.5 mclk_i = ~mclk_i;
  rmls_top DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .master_sel_i(ms), .input_select_i(isel),
    .smpte_processing_select_i(prc), .bus_width_select_i(bw), .carrier_detect_a_n_i(cda),
    .carrier_detect_b_n_i(cdb), .asi_mode_pin_i(aw), .asi_mode_pin_o(ao),
    .asi_mode_pin_oe_n_o(aoe), .rate_select_pin_i(rw), .rate_select_pin_o(ro),
    .rate_select_pin_oe_n_o(roe), .rx_rate_sd_i(sd), .rx_rate_valid_i(rv),
    .rx_smpte_lock_i(sl), .rx_asi_lock_i(al), .anc_chroma_i(ac), .anc_any_i(aa),
    .locked_o(lk), .chroma_anc_flag_o(fl), .output_mute_o(mu), .path_select_a_o(pa),
    .asi_decode_en_o(de), .rate_is_sd_o(rs));
  rmls_host_model host (.host_asi_i(ha), .host_rate_i(hr), .dev_asi_i(ao),
    .dev_asi_oe_n_i(aoe), .dev_rate_i(ro), .dev_rate_oe_n_i(roe), .asi_wire_o(aw),
    .rate_wire_o(rw));
  task automatic chk(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s mismatch", $time, what);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    chk(lk, RST_LOCK, "reset lock");
    chk(mu, RST_MUTE, "reset mute");
    chk(aoe, OE_RELEASE, "reset mode oe");
    chk(de, RST_DECODE, "reset decode");
    nrst_i = 1'b1;
    for (int p = 0; p < 40; p++) begin
      @(negedge mclk_i);
      ms = p[0];
      {isel, prc, bw, cda, cdb, ha} = 6'($random(seed));
      if (p % 4 == 1) {prc, ha} = 2'b01;
      if (!ms && hr != p[2]) begin
        hr = p[2];
        nrst_i = 1'b0;
        @(negedge mclk_i);
        nrst_i = 1'b1;
      end
      repeat (5) @(negedge mclk_i);
      repeat (20) begin
        @(negedge mclk_i);
        cok = isel ? ~cda : ~cdb;
        rt = ms ? sd : hr;
        asim = ms ? al : (ha & hr & ~prc);
        oe = ms ? OE_DRIVE : OE_RELEASE;
        chk(pa, isel, "path");
        chk(aoe, oe, "mode oe");
        chk(roe, oe, "rate oe");
        if (ms) begin
          chk(ao, cok & rv & al, "mode pin");
          chk(ro, sd, "rate pin");
        end
        chk(rs, rt, "rate level");
        chk(de, asim & cok, "decode");
        ex = cok & rv & (asim ? al : sl) & (ms | (sd == hr)) & (ms | prc | asim);
        chk(lk, ex, "lock");
        chk(mu, ~cok, "mute");
        ex = cok & ((rt == RATE_SD && !bw) ? aa : ac);
        chk(fl, ex, "flag");
        {sd, rv, sl, al, ac, aa} = 6'($random(seed));
      end
    end
    complete_run();
  end
endmodule
